//--- hw/spi_seq_device.sv
// Device end: serial command interpreter, sequential buffer and RAM copier
//
// Behaviour
// R01: Block write: opcode 0x04, count, address
// R02: Host gives byte count up to 255
// R03: Host keeps block address within 0x0000-0x2FFF
// R04: Block write ignores word 2, answers dummy
// R05: Host stages data before block write
// R06: Block write copies buffer into RAM
// R07: Word 0 bits 15/14 show error/busy
// R08: Word 0 echoes block-write address
// R09: Chunk read: opcode 0x05, count 1-4
// R10: Host reads four bytes except last
// R11: Chunk reads walk buffer from entry zero
// R12: Chunk read ignores MOSI words 1, 2
// R13: Chunk read word 0 shows error/busy
// R14: Chunk read echoes buffer base address; the code echoes SEQ_BUF_BASE plus four bytes per entry already read
// R15: Read bytes left-aligned in words 1, 2
// R16: Chunk write 0x06 stores 1-4 bytes sequentially
// R17: Block read fills buffer from RAM
// R18: Host may chain chunk reads without polling
// R19: Frame is three MSB-first words per select
// R20: Block commands reset both buffer pointers
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module spi_seq_device import spi_seq_pkg::*; (
	input wire logic mclk, // System clock, 125 MHz
	input wire logic resetn, // Async reset, active low
	spi_seq_if.device link, // Serial link to the host
	output logic [13:0] ramAddr, // RAM byte address
	output logic ramWrEn, // RAM write strobe
	output logic [7:0] ramWrData, // RAM write byte
	output logic ramRdEn, // RAM read strobe
	input wire logic [7:0] ramRdData, // RAM byte, cycle after ramRdEn
	output logic busy // Copy engine running
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_WRITE = 5'b00010,
		ST_RDREQ = 5'b00100,
		ST_RDWAIT = 5'b01000,
		ST_RDCAP = 5'b10000
	} eng_state_t;

	logic [2:0] pinS;
	logic sclkPrev_q, csnPrev_q;
	logic sclkRise, sclkFall, frameStart, frameEnd, frameDone;
	logic [47:0] rx_q;
	logic [5:0] rxCnt_q;
	logic hdr_q;
	logic [47:0] tx_q;
	logic [5:0] txIdx_q;
	logic miso_q;
	logic err_q;
	logic [13:0] echo_q;
	logic [6:0] rdPtr_q, wrPtr_q;
	logic [31:0] buf_q [BUF_ENTRIES];
	eng_state_t state_q;
	logic [7:0] idx_q, len_q;
	logic [13:0] base_q;
	logic idle;
	opcode_t fOp, hOp;
	logic [7:0] fLen, hLen;
	logic [15:0] fAddr;
	logic sqRange, startWr, startRd, chunkWr, chunkRd, cmdBad;
	logic [7:0] bufByte;

	////////////////////////////////////////////////////////////////////////
	// Pin capture and edge detection

	link_sync #(.WIDTH(3), .INIT(3'b010)) uSync (
		.mclk(mclk),
		.resetn(resetn),
		.din({link.sclk, link.csn, link.mosi}),
		.dout(pinS)
	);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sclkPrev_q <= 1'b0;
			csnPrev_q <= 1'b1;
		end else begin
			sclkPrev_q <= pinS[2];
			csnPrev_q <= pinS[1];
		end
	end

	assign sclkRise = !pinS[1] && pinS[2] && !sclkPrev_q;
	assign sclkFall = !pinS[1] && !pinS[2] && sclkPrev_q;
	assign frameStart = csnPrev_q && !pinS[1];
	assign frameEnd = !csnPrev_q && pinS[1];

	////////////////////////////////////////////////////////////////////////
	// Receive shifter

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rx_q <= 48'h0000_0000_0000;
			rxCnt_q <= 6'h00;
			hdr_q <= 1'b0;
		end else begin
			hdr_q <= sclkRise && (rxCnt_q == HDR_LAST);
			if (frameStart) begin
				rxCnt_q <= 6'h00;
			end else if (sclkRise && rxCnt_q != FRAME_BITS) begin
				rx_q <= {rx_q[46:0], pinS[0]}; // R19
				rxCnt_q <= rxCnt_q + 6'h01;
			end
		end
	end

	// A frame counts only with all three words in; a chunk read counts after word 0
	assign frameDone = frameEnd && (rxCnt_q == FRAME_BITS); // R19
	assign fOp = rx_q[47:40]; // R01
	assign fLen = rx_q[39:32]; // R01
	assign fAddr = rx_q[31:16]; // R01 R04
	assign hOp = rx_q[15:8]; // R09
	assign hLen = rx_q[7:0]; // R09

	////////////////////////////////////////////////////////////////////////
	// Command decode

	assign idle = (state_q == ST_IDLE);
	assign sqRange = (fAddr <= RAM_LAST)
		&& ({1'b0, fAddr} + {9'h000, fLen} <= {1'b0, RAM_LAST} + 17'h0_0001);
	assign startWr = frameDone && fOp == OP_BLOCK_WRITE && idle && sqRange;
	assign startRd = frameDone && fOp == OP_BLOCK_READ && idle && sqRange;
	assign chunkWr = frameDone && fOp == OP_CHUNK_WRITE && idle
		&& len_ok(fLen) && !wrPtr_q[6]; // R16
	// Decided after word 0 so the data can go out in words 1 and 2
	assign chunkRd = hdr_q && hOp == OP_CHUNK_READ && idle
		&& len_ok(hLen) && !rdPtr_q[6]; // R09 R12 R18
	assign cmdBad = (frameDone && fOp != OP_CHUNK_READ
		&& !(startWr || startRd || chunkWr))
		|| (hdr_q && hOp == OP_CHUNK_READ && !chunkRd);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			err_q <= 1'b0;
			echo_q <= ECHO_RST;
			rdPtr_q <= PTR_RST;
			wrPtr_q <= PTR_RST;
		end else if (startWr || startRd) begin
			err_q <= 1'b0;
			echo_q <= fAddr[13:0]; // R08
			rdPtr_q <= PTR_RST; // R20
			wrPtr_q <= PTR_RST; // R20
		end else if (chunkWr) begin
			err_q <= 1'b0;
			echo_q <= SEQ_BUF_BASE + {6'h00, wrPtr_q[5:0], 2'b00};
			wrPtr_q <= wrPtr_q + 7'h01; // R16
		end else if (chunkRd) begin
			err_q <= 1'b0;
			echo_q <= SEQ_BUF_BASE + {6'h00, rdPtr_q[5:0], 2'b00}; // R14
			rdPtr_q <= rdPtr_q + 7'h01; // R11
		end else if (cmdBad) begin
			err_q <= 1'b1; // R07 R13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit shifter

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx_q <= 48'h0000_0000_0000;
			txIdx_q <= 6'h00;
			miso_q <= 1'b0;
		end else if (frameStart) begin
			// Status of the previous command, data words blank
			tx_q <= {err_q, !idle, echo_q, 32'h0000_0000}; // R07 R08 R13 R04
			txIdx_q <= TX_FIRST;
			miso_q <= err_q;
		end else begin
			if (hdr_q && hOp == OP_CHUNK_READ) begin
				tx_q[31:0] <= chunkRd
					? keep_bytes(buf_q[rdPtr_q[5:0]], hLen) // R11 R15
					: 32'h0000_0000;
			end
			if (sclkFall && txIdx_q != 6'h00) begin
				miso_q <= tx_q[txIdx_q - 6'h01]; // R19
				txIdx_q <= txIdx_q - 6'h01;
			end
		end
	end

	assign link.miso = miso_q;

	////////////////////////////////////////////////////////////////////////
	// Sequential buffer

	assign bufByte = buf_q[idx_q[7:2]][{~idx_q[1:0], 3'b000} +: 8];

	always_ff @(posedge mclk) begin
		if (chunkWr) begin
			buf_q[wrPtr_q[5:0]] <= keep_bytes(rx_q[31:0], fLen); // R16
		end else if (state_q == ST_RDCAP) begin
			buf_q[idx_q[7:2]][{~idx_q[1:0], 3'b000} +: 8] <= ramRdData; // R17
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Copy engine between buffer and RAM

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			idx_q <= 8'h00;
			len_q <= 8'h00;
			base_q <= 14'h0000;
			ramAddr <= 14'h0000;
			ramWrEn <= 1'b0;
			ramWrData <= 8'h00;
			ramRdEn <= 1'b0;
		end else begin
			ramWrEn <= 1'b0;
			ramRdEn <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					idx_q <= 8'h00;
					len_q <= fLen; // R02
					base_q <= fAddr[13:0]; // R03
					if (startWr) begin
						state_q <= ST_WRITE; // R06
					end else if (startRd) begin
						state_q <= ST_RDREQ; // R17
					end
				end
				ST_WRITE: begin
					if (idx_q == len_q) begin
						state_q <= ST_IDLE;
					end else begin
						ramWrEn <= 1'b1; // R06
						ramAddr <= base_q + {6'h00, idx_q};
						ramWrData <= bufByte; // R05
						idx_q <= idx_q + 8'h01;
					end
				end
				ST_RDREQ: begin
					if (idx_q == len_q) begin
						state_q <= ST_IDLE;
					end else begin
						ramRdEn <= 1'b1;
						ramAddr <= base_q + {6'h00, idx_q};
						state_q <= ST_RDWAIT;
					end
				end
				ST_RDWAIT: begin
					state_q <= ST_RDCAP;
				end
				ST_RDCAP: begin
					idx_q <= idx_q + 8'h01;
					state_q <= ST_RDREQ;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign busy = !idle; // R07 R13
endmodule : spi_seq_device

//--- inc/spi_seq_pkg.sv
// Shared constants, types and helpers for the serial buffer command link
package spi_seq_pkg;

	typedef logic [7:0] opcode_t;
	localparam opcode_t OP_BLOCK_READ = 8'h03;
	localparam opcode_t OP_BLOCK_WRITE = 8'h04;
	localparam opcode_t OP_CHUNK_READ = 8'h05;
	localparam opcode_t OP_CHUNK_WRITE = 8'h06;

	// Frame layout: three 16-bit words, MSB first
	localparam logic [5:0] FRAME_BITS = 6'h30;
	localparam logic [5:0] HDR_LAST = 6'h0F;
	localparam logic [5:0] TX_FIRST = 6'h2F;
	localparam int ERR_BIT = 15;
	localparam int BUSY_BIT = 14;

	// Sequential buffer: 64 entries of 32 bits
	localparam int BUF_ENTRIES = 64;
	localparam logic [15:0] RAM_LAST = 16'h2FFF;
	localparam logic [13:0] SEQ_BUF_BASE = 14'h3100;

	// Reset values
	localparam logic [13:0] ECHO_RST = 14'h0000;
	localparam logic [6:0] PTR_RST = 7'h00;

	// Link timing, host-made clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_PERIOD_NS = 128;
	localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
		/ (2 * CLK_PERIOD_NS);
	localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
	localparam logic [7:0] GAP_LAST = 8'h0F;

	// Host register map (byte addresses)
	localparam logic [7:0] REG_CMD0 = 8'h00;
	localparam logic [7:0] REG_CMD1 = 8'h04;
	localparam logic [7:0] REG_CMD2 = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RSP0 = 8'h14;
	localparam logic [7:0] REG_RSP1 = 8'h18;
	localparam logic [7:0] REG_RSP2 = 8'h1C;

	// Keep the top len bytes of a left-aligned word
	function automatic logic [31:0] keep_bytes(input logic [31:0] d,
		input logic [7:0] len);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (len > 8'(i)) begin
				m[31 - 8 * i -: 8] = 8'hFF;
			end
		end
		return d & m;
	endfunction : keep_bytes

	// A chunk length is legal from 1 to 4 bytes
	function automatic logic len_ok(input logic [7:0] len);
		return (len != 8'h00) && (len <= 8'h04);
	endfunction : len_ok

endpackage : spi_seq_pkg

//--- inc/spi_seq_if.sv
// Four-wire serial link between host and device
`timescale 1ns/1ps
interface spi_seq_if;
	logic sclk;
	logic csn;
	logic mosi;
	logic miso;

	modport device (
		input sclk,
		input csn,
		input mosi,
		output miso
	);

	modport host (
		output sclk,
		output csn,
		output mosi,
		input miso
	);
endinterface : spi_seq_if

//--- hw/link_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module link_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic mclk, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic [WIDTH-1:0] din, // Asynchronous pins
	output logic [WIDTH-1:0] dout // Synchronised levels
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= INIT;
			dout <= INIT;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : link_sync

//--- hw/spi_seq_host.sv
// Host end: link master driven by software over Avalon-MM registers
`timescale 1ns/1ps
module spi_seq_host import spi_seq_pkg::*; (
	input wire logic mclk, // System clock, 125 MHz
	input wire logic resetn, // Async reset, active low
	spi_seq_if.host link, // Serial link to the device
	input wire logic [7:0] address, // Avalon byte address
	input wire logic read, // Avalon read request
	input wire logic write, // Avalon write request
	input wire logic [31:0] writedata, // Avalon write data
	output logic [31:0] readdata, // Avalon read data
	output logic waitrequest // Avalon stall
);
	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001,
		HS_CLKLO = 5'b00010,
		HS_CLKHI = 5'b00100,
		HS_TAIL = 5'b01000,
		HS_GAP = 5'b10000
	} host_state_t;

	logic ack_q;
	logic [15:0] cmd0_q, cmd1_q, cmd2_q;
	logic [47:0] rsp_q;
	logic done_q;
	host_state_t state_q;
	logic [7:0] div_q;
	logic [5:0] bit_q;
	logic [47:0] shTx_q, shRx_q;
	logic sclk_q, csn_q, mosi_q;
	logic misoS;
	logic wrTake, start;

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: answers at the second edge of every request

	assign waitrequest = (read || write) && !ack_q;
	assign wrTake = write && ack_q;
	assign start = wrTake && address == REG_CTRL && writedata[0]
		&& state_q == HS_IDLE;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			ack_q <= (read || write) && !ack_q;
			if (read && !ack_q) begin
				unique case (address)
					REG_CMD0: readdata <= {16'h0000, cmd0_q};
					REG_CMD1: readdata <= {16'h0000, cmd1_q};
					REG_CMD2: readdata <= {16'h0000, cmd2_q};
					REG_STATUS: readdata <= {30'h000_0000, done_q,
						state_q != HS_IDLE};
					REG_RSP0: readdata <= {16'h0000, rsp_q[47:32]};
					REG_RSP1: readdata <= {16'h0000, rsp_q[31:16]};
					REG_RSP2: readdata <= {16'h0000, rsp_q[15:0]};
					default: readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmd0_q <= 16'h0000;
			cmd1_q <= 16'h0000;
			cmd2_q <= 16'h0000;
		end else if (wrTake) begin
			if (address == REG_CMD0) begin
				cmd0_q <= writedata[15:0]; // R01 R09
			end
			if (address == REG_CMD1) begin
				cmd1_q <= writedata[15:0]; // R03
			end
			if (address == REG_CMD2) begin
				cmd2_q <= writedata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link master: makes the clock, mode 0, MSB first

	link_sync #(.WIDTH(1), .INIT(1'b0)) uSync (
		.mclk(mclk),
		.resetn(resetn),
		.din(link.miso),
		.dout(misoS)
	);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= HS_IDLE;
			div_q <= 8'h00;
			bit_q <= 6'h00;
			shTx_q <= 48'h0000_0000_0000;
			shRx_q <= 48'h0000_0000_0000;
			rsp_q <= 48'h0000_0000_0000;
			done_q <= 1'b0;
			sclk_q <= 1'b0;
			csn_q <= 1'b1;
			mosi_q <= 1'b0;
		end else begin
			div_q <= div_q + 8'h01;
			unique case (state_q)
				HS_IDLE: begin
					div_q <= 8'h00;
					bit_q <= 6'h00;
					if (start) begin
						shTx_q <= {cmd0_q, cmd1_q, cmd2_q}; // R19
						mosi_q <= cmd0_q[15];
						csn_q <= 1'b0;
						done_q <= 1'b0;
						state_q <= HS_CLKLO;
					end
				end
				HS_CLKLO: begin
					if (div_q == HALF_LAST) begin
						div_q <= 8'h00;
						sclk_q <= 1'b1;
						shRx_q <= {shRx_q[46:0], misoS}; // R19
						state_q <= HS_CLKHI;
					end
				end
				HS_CLKHI: begin
					if (div_q == HALF_LAST) begin
						div_q <= 8'h00;
						sclk_q <= 1'b0;
						bit_q <= bit_q + 6'h01;
						shTx_q <= {shTx_q[46:0], 1'b0};
						mosi_q <= shTx_q[46];
						state_q <= (bit_q == TX_FIRST) ? HS_TAIL : HS_CLKLO;
					end
				end
				HS_TAIL: begin
					if (div_q == HALF_LAST) begin
						div_q <= 8'h00;
						csn_q <= 1'b1;
						rsp_q <= shRx_q; // R07 R13
						done_q <= 1'b1;
						state_q <= HS_GAP;
					end
				end
				HS_GAP: begin
					if (div_q == GAP_LAST) begin
						state_q <= HS_IDLE;
					end
				end
				default: begin
					state_q <= HS_IDLE;
				end
			endcase
		end
	end

	assign link.sclk = sclk_q;
	assign link.csn = csn_q;
	assign link.mosi = mosi_q;
endmodule : spi_seq_host

//--- verif/spi_seq_props.sv
// Concurrent checks on the serial link and the RAM copy port
`timescale 1ns/1ps
module spi_seq_props import spi_seq_pkg::*; (
	input wire logic mclk, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic sclk, // Link clock
	input wire logic csn, // Chip select, active low
	input wire logic mosi, // Host data
	input wire logic miso, // Device data
	input wire logic [13:0] ramAddr, // RAM address
	input wire logic ramWrEn, // RAM write strobe
	input wire logic ramRdEn, // RAM read strobe
	input wire logic busy // Copy engine running
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic sclk_q;
	logic [5:0] bitCnt_q;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
		end
	end
	// Rising link clock edges within one select, cleared while deselected
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bitCnt_q <= 6'h00;
		end else if (csn) begin
			bitCnt_q <= 6'h00;
		end else if (sclk && !sclk_q) begin
			bitCnt_q <= bitCnt_q + 6'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_frameEnd;
		$rose(csn);
	endsequence
	sequence s_burstEnd;
		$fell(ramWrEn);
	endsequence
	a_frame_bits: assert property (s_frameEnd |-> bitCnt_q == FRAME_BITS)
		else $error("frame length differs from three words");
	a_select_clock_low: assert property ($fell(csn) |-> !sclk)
		else $error("link clock high at select");
	a_gap_clock_idle: assert property (csn |-> !sclk)
		else $error("link clock runs outside frame");
	a_mosi_held_high: assert property (!csn && sclk && sclk_q
		|-> $stable(mosi))
		else $error("host data moved while clock high");
	a_miso_held_high: assert property (!csn && sclk && sclk_q
		|-> $stable(miso))
		else $error("device data moved while clock high");
	a_write_needs_busy: assert property (ramWrEn |-> busy)
		else $error("RAM write outside copy");
	a_copy_after_frame: assert property ($rose(busy) |-> csn)
		else $error("copy started inside a frame");
	a_write_addr_step: assert property (ramWrEn && $past(ramWrEn)
		|-> ramAddr == $past(ramAddr) + 14'h0001)
		else $error("RAM write address not consecutive");
	a_burst_end_idle: assert property (s_burstEnd |-> ##[0:2] !busy)
		else $error("busy stays after copy");
	a_read_spacing: assert property (ramRdEn |=> !ramRdEn ##1 !ramRdEn)
		else $error("RAM reads closer than three cycles");
endmodule : spi_seq_props

//--- verif/testbench.sv
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
module testbench;
	import spi_seq_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic waitrequest;
	logic [13:0] ramAddr;
	logic ramWrEn;
	logic ramRdEn;
	logic busy;
	logic [7:0] ramWrData;
	logic [7:0] ramRdData = 8'h00;
	logic [7:0] ram [0:16383];
	logic [31:0] rsp [0:2];
	int errors = 0;
	int total_checks = 0;
	spi_seq_if link_if();
	spi_seq_host spi_seq_host_i(.mclk(mclk), .resetn(resetn),
		.link(link_if.host), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
	spi_seq_device spi_seq_device_i(.mclk(mclk), .resetn(resetn),
		.link(link_if.device), .ramAddr(ramAddr), .ramWrEn(ramWrEn),
		.ramWrData(ramWrData), .ramRdEn(ramRdEn), .ramRdData(ramRdData),
		.busy(busy));
	spi_seq_props spi_seq_props_i(.mclk(mclk), .resetn(resetn),
		.sclk(link_if.sclk), .csn(link_if.csn), .mosi(link_if.mosi),
		.miso(link_if.miso), .ramAddr(ramAddr), .ramWrEn(ramWrEn),
		.ramRdEn(ramRdEn), .busy(busy));
	always #4 mclk = ~mclk;
	// Process RAM with one cycle of read latency
	always @(posedge mclk) begin
		if (ramWrEn) begin
			ram[ramAddr] <= ramWrData;
		end
		if (ramRdEn) begin
			ramRdData <= ram[ramAddr];
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic av(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		// Request stands until the edge that sees waitrequest low
		do begin
			@(posedge mclk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : av
	task automatic frame(input logic [15:0] w0, input logic [15:0] w1,
		input logic [15:0] w2);
		logic [31:0] q;
		av(1'b1, REG_CMD0, {16'h0000, w0}, q);
		av(1'b1, REG_CMD1, {16'h0000, w1}, q);
		av(1'b1, REG_CMD2, {16'h0000, w2}, q);
		av(1'b1, REG_CTRL, 32'h0000_0001, q);
		do begin
			av(1'b0, REG_STATUS, 32'h0000_0000, q);
		end while (q[1] !== 1'b1);
		for (int i = 0; i < 3; i++) begin
			av(1'b0, REG_RSP0 + 8'(4 * i), 32'h0000_0000, rsp[i]);
		end
	endtask : frame
	////////////////////////////////////////////////////////////////////////
	task automatic t_write();
		logic [87:0] exp;
		exp = 88'h11_2233_4455_6677_8899_AA00;
		frame({OP_CHUNK_WRITE, 8'h04}, 16'h1122, 16'h3344);
		frame({OP_CHUNK_WRITE, 8'h04}, 16'h5566, 16'h7788);
		frame({OP_CHUNK_WRITE, 8'h02}, 16'h99AA, 16'hBBCC);
		frame({OP_BLOCK_WRITE, 8'h0A}, 16'h0100, 16'hFFFF);
		frame({OP_BLOCK_READ, 8'h0A}, 16'h0100, 16'h0000);
		check(rsp[0], 32'h0000_0100);
		for (int i = 0; i < 11; i++) begin
			check(32'(ram[14'h0100 + 14'(i)]), 32'(exp[87 - 8 * i -: 8]));
		end
	endtask : t_write
	task automatic t_read();
		logic [31:0] expd [0:2];
		logic [7:0] lens [0:2];
		expd = '{32'h1122_3344, 32'h5566_7788, 32'h99AA_0000};
		lens = '{8'h04, 8'h04, 8'h02};
		for (int i = 0; i < 3; i++) begin
			frame({OP_CHUNK_READ, lens[i]}, 16'hFFFF, 16'hA5A5);
			check({rsp[1][15:0], rsp[2][15:0]}, expd[i]);
			// Word 0 reports the chunk read before this one
			if (i > 0) begin
				check(rsp[0], {18'h0000, SEQ_BUF_BASE + 14'(4 * (i - 1))});
			end
		end
		frame({OP_BLOCK_READ, 8'h04}, 16'h0100, 16'h0000);
		frame({OP_CHUNK_READ, 8'h01}, 16'h0000, 16'h0000);
		check({rsp[1][15:0], rsp[2][15:0]}, 32'h1100_0000);
	endtask : t_read
	task automatic t_busy();
		frame({OP_BLOCK_WRITE, 8'hFF}, 16'h0000, 16'h0000);
		frame({OP_BLOCK_READ, 8'h01}, 16'h0000, 16'h0000);
		check(rsp[0], 32'h0000_4000);
	endtask : t_busy
	task automatic t_errors();
		logic [15:0] bad [0:3][0:1];
		bad = '{'{16'h0505, 16'h0000}, '{16'h0500, 16'h0000},
			'{16'h0402, 16'h2FFF}, '{16'h0701, 16'h0000}};
		for (int i = 0; i < 4; i++) begin
			frame(bad[i][0], bad[i][1], 16'h0000);
			frame({OP_BLOCK_READ, 8'h01}, 16'h0000, 16'h0000);
			check(rsp[0][15:14], 32'h0000_0002);
		end
		frame({OP_BLOCK_READ, 8'h01}, 16'h0000, 16'h0000);
		check(rsp[0][15:14], 32'h0000_0000);
	endtask : t_errors
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		for (int i = 0; i < 16384; i++) begin
			ram[i] = 8'h00;
		end
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		t_write();
		t_read();
		t_busy();
		t_errors();
		end_of_test();
	end
	// Some twenty frames of under a thousand cycles each
	initial begin
		#480000;
		errors++;
		end_of_test();
	end
endmodule : testbench
